// File: hw/hwc_consts.svh
// Named constants for the hardware cursor register block
`ifndef HWC_CONSTS_SVH
`define HWC_CONSTS_SVH

// Register block pointer value that selects the cursor block
`define HWC_BLOCK_CURSOR   8'h02

// Indexed register numbers inside the cursor block
`define HWC_IDX_CTRL       4'h0
`define HWC_IDX_ADDR_LO    4'h1
`define HWC_IDX_ADDR_HI    4'h2
`define HWC_IDX_COL_FIRST  4'h3
`define HWC_IDX_COL_SECOND 4'h4
`define HWC_IDX_ORIGIN     4'h5
`define HWC_IDX_POS_X      4'h6
`define HWC_IDX_POS_Y      4'h7
`define HWC_IDX_COL_THIRD  4'h8
`define HWC_NUM_REGS       9

// Word layout at the access port
`define HWC_WORD_IDX_HI    15
`define HWC_WORD_IDX_LO    12
`define HWC_WORD_DATA_HI   11

// Control register fields
`define HWC_CTL_EN_BIT     11
`define HWC_CTL_SIZE_HI    10
`define HWC_CTL_SIZE_LO    9
`define HWC_CTL_PROT_BIT   8
`define HWC_CTL_MODE_HI    7
`define HWC_CTL_MODE_LO    5
`define HWC_SIZE_32        2'b00
`define HWC_SIZE_64        2'b01

// Origin, position, colour and address fields
`define HWC_ORG_Y_HI       11
`define HWC_ORG_Y_LO       6
`define HWC_ORG_X_HI       5
`define HWC_ORG_X_LO       0
`define HWC_POS_HI         10
`define HWC_BYTE_HI        7

// Index control register fields
`define HWC_IC_PTR_HI      7
`define HWC_IC_IDX_HI      11
`define HWC_IC_IDX_LO      8
`define HWC_IC_AINC_BIT    12

// Port select on address bit 1: index control or access port
`define HWC_PORT_IC        1'b0
`define HWC_PORT_ACC       1'b1
`define HWC_BE_BOTH        2'b11

// Pattern spans in pixels
`define HWC_SPAN_32        13'h0020
`define HWC_SPAN_64        13'h0040

// Reset values
`define HWC_RST_WORD       12'h000
`define HWC_RST_PTR        8'h00
`define HWC_RST_IDX        4'h0

`endif

// File: hw/hwc_pkg.sv
// Types shared by the hardware cursor register block
`default_nettype none
package hwc_pkg;

	// Host I/O request at the index control / access ports
	typedef struct packed {
		logic        sel;    // Access to the 23C0h..23C3h range
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
		logic        port;   // Address bit 1: 0 index control, 1 access port
		logic [1:0]  be;     // Byte enables, bit 1 is the high byte
		logic [15:0] wdata;  // Write data
	} hwc_io_req_s;

	// Decoded cursor block access, one cycle pulses
	typedef struct packed {
		logic        wr;     // Write to a cursor register
		logic        rd;     // Read of a cursor register
		logic [3:0]  idx;    // Register index
		logic [11:0] data;   // Write data field
	} hwc_acc_s;

	// Applied control fields
	typedef struct packed {
		logic       en;
		logic [1:0] size;
		logic       prot;
		logic [2:0] mode;
	} hwc_ctl_s;

endpackage : hwc_pkg
`default_nettype wire

// File: hw/hwc_index_port.sv
// Index control register and access port decode for the cursor block
`include "hwc_consts.svh"
`default_nettype none
module hwc_index_port (
	input  wire logic                 clock,    // 125 MHz clock
	input  wire logic                 rst_n,    // Async reset, active low
	input  wire hwc_pkg::hwc_io_req_s io_req,   // Host port request
	output hwc_pkg::hwc_acc_s         acc,      // Decoded cursor access
	output logic [15:0]               ic_word   // Index control read value
);
	import hwc_pkg::*;

	typedef struct packed {
		logic [7:0] ptr;
		logic [3:0] idx;
		logic       ainc_dis;
	} hwc_ic_state_s;

	hwc_ic_state_s st_q;
	hwc_ic_state_s st_d;
	logic          blk_hit;

	// Cursor block only answers while the pointer selects it
	assign blk_hit = (st_q.ptr == `HWC_BLOCK_CURSOR);

	// Access decode; a partial write at the access port is dropped, the index would be torn
	always_comb begin
		acc.wr   = io_req.sel && io_req.wr && (io_req.port == `HWC_PORT_ACC)
			&& (io_req.be == `HWC_BE_BOTH) && blk_hit;
		acc.rd   = io_req.sel && io_req.rd && (io_req.port == `HWC_PORT_ACC) && blk_hit;
		acc.idx  = acc.wr ? io_req.wdata[`HWC_WORD_IDX_HI:`HWC_WORD_IDX_LO] : st_q.idx;
		acc.data = io_req.wdata[`HWC_WORD_DATA_HI:0];
		ic_word  = {2'b00, !blk_hit, st_q.ainc_dis, st_q.idx, st_q.ptr};
	end

	// Pointer, read index and auto-increment
	always_comb begin
		st_d = st_q;
		if (io_req.sel && io_req.wr && (io_req.port == `HWC_PORT_IC)) begin
			if (io_req.be[0]) begin
				st_d.ptr = io_req.wdata[`HWC_IC_PTR_HI:0];
			end
			if (io_req.be[1]) begin
				st_d.idx      = io_req.wdata[`HWC_IC_IDX_HI:`HWC_IC_IDX_LO];
				st_d.ainc_dis = io_req.wdata[`HWC_IC_AINC_BIT];
			end
		end else if (acc.rd && !st_q.ainc_dis) begin
			st_d.idx = st_q.idx + 4'h1; // Wraps from Fh to 0
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{ptr: `HWC_RST_PTR, idx: `HWC_RST_IDX, ainc_dis: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

endmodule : hwc_index_port
`default_nettype wire

// File: hw/hwc_hit_window.sv
// Beam against cursor window test and pattern pixel coordinates
`include "hwc_consts.svh"
`default_nettype none
module hwc_hit_window (
	input  wire logic        clock,     // 125 MHz clock
	input  wire logic        rst_n,     // Async reset, active low
	input  wire logic        show,      // Cursor may be drawn
	input  wire logic        big,       // 64 by 64 pattern
	input  wire logic [10:0] beam_x,    // Current pixel column
	input  wire logic [10:0] beam_y,    // Current pixel row
	input  wire logic [10:0] pos_x,     // Applied screen position X
	input  wire logic [10:0] pos_y,     // Applied screen position Y
	input  wire logic [5:0]  org_x,     // Applied hot-spot X
	input  wire logic [5:0]  org_y,     // Applied hot-spot Y
	output logic             hit,       // Beam inside the pattern
	output logic [5:0]       pat_col,   // Pattern column at the beam
	output logic [5:0]       pat_row    // Pattern row at the beam
);
	import hwc_pkg::*;

	typedef struct packed {
		logic       hit;
		logic [5:0] col;
		logic [5:0] row;
	} hwc_hit_state_s;

	hwc_hit_state_s st_q;
	hwc_hit_state_s st_d;
	logic [12:0]    dx;
	logic [12:0]    dy;
	logic [12:0]    span;

	// Hot-spot sits on the position, so pattern col = beam - pos + origin
	always_comb begin
		span = big ? `HWC_SPAN_64 : `HWC_SPAN_32;
		dx   = {2'b00, beam_x} + {7'h00, org_x} - {2'b00, pos_x};
		dy   = {2'b00, beam_y} + {7'h00, org_y} - {2'b00, pos_y};
		st_d.hit = show && !dx[12] && !dy[12] && (dx < span) && (dy < span);
		st_d.col = dx[5:0];
		st_d.row = dy[5:0];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{hit: 1'b0, col: 6'h00, row: 6'h00};
		end else begin
			st_q <= st_d;
		end
	end

	assign hit     = st_q.hit;
	assign pat_col = st_q.col;
	assign pat_row = st_q.row;

endmodule : hwc_hit_window
`default_nettype wire

// File: hw/hwc_cursor.sv
// Hardware cursor register block with frame-synchronous (field-synchronous when interlaced) update of applied address, origin and position
`include "hwc_consts.svh"
`default_nettype none
module hwc_cursor (
	input  wire logic                 clock,        // 125 MHz clock
	input  wire logic                 rst_n,        // Async reset, active low
	input  wire hwc_pkg::hwc_io_req_s io_req,       // Host I/O request
	output logic [15:0]               io_rdata,     // Read data
	output logic                      io_rvalid,    // Read data valid, one cycle
	input  wire logic                 frame_start,  // Start of video frame pulse
	input  wire logic                 field_start,  // Start of video field pulse
	input  wire logic                 interlaced,   // Display is interlaced
	input  wire logic [10:0]          beam_x,       // Current pixel column
	input  wire logic [10:0]          beam_y,       // Current pixel row
	output logic                      cur_shown,    // Cursor enabled with legal codes
	output hwc_pkg::hwc_ctl_s         cur_ctl,      // Applied control fields
	output logic [19:0]               cur_addr,     // Applied pattern address
	output logic [5:0]                cur_org_x,    // Applied hot-spot X
	output logic [5:0]                cur_org_y,    // Applied hot-spot Y
	output logic [10:0]               cur_pos_x,    // Applied position X
	output logic [10:0]               cur_pos_y,    // Applied position Y
	output logic [7:0]                col_first,    // Primary colour
	output logic [7:0]                col_second,   // Secondary colour
	output logic [7:0]                col_third,    // Auxiliary colour
	output logic                      cur_hit,      // Beam inside cursor pattern
	output logic [5:0]                pat_col,      // Pattern column at the beam
	output logic [5:0]                pat_row       // Pattern row at the beam
);
	import hwc_pkg::*;

	// Everything this module remembers
	typedef struct packed {
		logic [`HWC_NUM_REGS-1:0][11:0] shadow;  // Last written words
		logic                           arm;     // Control written, commit pending
		logic [19:0]                    addr;    // Applied pattern address
		logic [11:0]                    org;     // Applied origin word
		logic [19:0]                    stage_addr; // Address captured at the control write
		logic [11:0]                    stage_org;  // Origin captured at the control write
		logic [10:0]                    pos_x;
		logic [10:0]                    pos_y;
		logic                           shown;
		hwc_ctl_s                       ctl;
		logic [15:0]                    rdata;
		logic                           rvalid;
	} hwc_state_s;

	hwc_state_s st_q;
	hwc_state_s st_d;
	hwc_acc_s   acc;
	logic [15:0] ic_word;
	logic        tick;

	// Split a control word into its fields
	function automatic hwc_ctl_s hwc_ctl_fields(input logic [11:0] w);
		hwc_ctl_s c;
		c.en   = w[`HWC_CTL_EN_BIT];
		c.size = w[`HWC_CTL_SIZE_HI:`HWC_CTL_SIZE_LO];
		c.prot = w[`HWC_CTL_PROT_BIT];
		c.mode = w[`HWC_CTL_MODE_HI:`HWC_CTL_MODE_LO];
		return c;
	endfunction : hwc_ctl_fields

	// Cursor may show only when enabled and both codes are defined
	function automatic logic hwc_ctl_show(input logic [11:0] w);
		hwc_ctl_s c;
		c = hwc_ctl_fields(w);
		return c.en && !c.size[1] && !c.mode[2];
	endfunction : hwc_ctl_show

	hwc_index_port u_port (
		.clock   (clock),
		.rst_n   (rst_n),
		.io_req  (io_req),
		.acc     (acc),
		.ic_word (ic_word)
	);

	// Updates land on the frame, or on the field when interlaced
	assign tick = interlaced ? field_start : frame_start;

	// Register writes, readback and frame-synchronous commit
	always_comb begin
		st_d        = st_q;
		st_d.rvalid = 1'b0;
		for (int i = 0; i < `HWC_NUM_REGS; i++) begin
			if (acc.wr && (acc.idx == 4'(i))) begin
				st_d.shadow[i] = acc.data;
			end
		end
		// Control applies at once; the displayed state follows it directly
		st_d.ctl   = hwc_ctl_fields(st_d.shadow[`HWC_IDX_CTRL]);
		st_d.shown = hwc_ctl_show(st_d.shadow[`HWC_IDX_CTRL]);
		// Commit of address and origin waits for a control write then a tick: a frame start, or a field start when interlaced
		if (st_q.arm && tick) begin
			st_d.addr = st_q.stage_addr;
			st_d.org  = st_q.stage_org;
		end
		// A control write in the tick cycle re-arms, so it is never lost
		if (acc.wr && (acc.idx == `HWC_IDX_CTRL)) begin
			st_d.arm        = 1'b1;
			// Snapshot now, so address or origin written after this wait for the next control write
			st_d.stage_addr = {st_q.shadow[`HWC_IDX_ADDR_HI][`HWC_BYTE_HI:0],
				st_q.shadow[`HWC_IDX_ADDR_LO]};
			st_d.stage_org  = st_q.shadow[`HWC_IDX_ORIGIN];
		end else if (tick) begin
			st_d.arm = 1'b0;
		end
		// Position follows its shadow at every tick: each frame start, or each field start when interlaced
		if (tick) begin
			st_d.pos_x = st_q.shadow[`HWC_IDX_POS_X][`HWC_POS_HI:0];
			st_d.pos_y = st_q.shadow[`HWC_IDX_POS_Y][`HWC_POS_HI:0];
		end
		// Read answers one cycle later; empty indices give a zero data field
		if (io_req.sel && io_req.rd) begin
			st_d.rvalid = 1'b1;
			if (io_req.port == `HWC_PORT_IC) begin
				st_d.rdata = ic_word;
			end else if (!acc.rd) begin
				st_d.rdata = 16'h0000;
			end else if (acc.idx < 4'(`HWC_NUM_REGS)) begin
				st_d.rdata = {acc.idx, st_q.shadow[acc.idx]};
			end else begin
				st_d.rdata = {acc.idx, `HWC_RST_WORD};
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign io_rdata   = st_q.rdata;
	assign io_rvalid  = st_q.rvalid;
	assign cur_shown  = st_q.shown;
	assign cur_ctl    = st_q.ctl;
	assign cur_addr   = st_q.addr;
	assign cur_org_x  = st_q.org[`HWC_ORG_X_HI:`HWC_ORG_X_LO];
	assign cur_org_y  = st_q.org[`HWC_ORG_Y_HI:`HWC_ORG_Y_LO];
	assign cur_pos_x  = st_q.pos_x;
	assign cur_pos_y  = st_q.pos_y;
	assign col_first  = st_q.shadow[`HWC_IDX_COL_FIRST][`HWC_BYTE_HI:0];
	assign col_second = st_q.shadow[`HWC_IDX_COL_SECOND][`HWC_BYTE_HI:0];
	assign col_third  = st_q.shadow[`HWC_IDX_COL_THIRD][`HWC_BYTE_HI:0];

	// Pixel-unit window test, independent of the display mode
	hwc_hit_window u_hit (
		.clock   (clock),
		.rst_n   (rst_n),
		.show    (st_q.shown),
		.big     (st_q.ctl.size == `HWC_SIZE_64),
		.beam_x  (beam_x),
		.beam_y  (beam_y),
		.pos_x   (st_q.pos_x),
		.pos_y   (st_q.pos_y),
		.org_x   (st_q.org[`HWC_ORG_X_HI:`HWC_ORG_X_LO]),
		.org_y   (st_q.org[`HWC_ORG_Y_HI:`HWC_ORG_Y_LO]),
		.hit     (cur_hit),
		.pat_col (pat_col),
		.pat_row (pat_row)
	);

	// Writes with another block selected leave the cursor registers alone
	blk_select_a: assert property (@(posedge clock) disable iff (!rst_n)
		(io_req.sel && io_req.wr && io_req.port == `HWC_PORT_ACC
			&& ic_word[`HWC_IC_PTR_HI:0] != `HWC_BLOCK_CURSOR)
		|=> st_q.shadow == $past(st_q.shadow))
		else $error("cursor register changed with another block selected");

	// Read word carries the index that was read
	read_index_a: assert property (@(posedge clock) disable iff (!rst_n)
		acc.rd |=> io_rvalid && io_rdata[`HWC_WORD_IDX_HI:`HWC_WORD_IDX_LO] == $past(acc.idx))
		else $error("read word index does not match");

	// Enable bit clear keeps the cursor hidden
	enable_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_CTRL && !acc.data[`HWC_CTL_EN_BIT])
		|=> !cur_shown ##1 !cur_hit)
		else $error("cursor shown while disabled");

	// Reserved codes keep the cursor hidden
	reserved_code_a: assert property (@(posedge clock) disable iff (!rst_n)
		(cur_ctl.size[1] || cur_ctl.mode[2]) |-> !cur_shown)
		else $error("cursor shown with reserved code");

	// Control fields reach the outputs the cycle after the write
	ctl_fields_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_CTRL)
		|=> cur_ctl.prot == $past(acc.data[`HWC_CTL_PROT_BIT])
			&& cur_ctl.mode == $past(acc.data[`HWC_CTL_MODE_HI:`HWC_CTL_MODE_LO]))
		else $error("control fields not applied");

	// Address moves only on a tick with a commit pending
	addr_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(!st_q.arm || !tick) |=> $stable(cur_addr) && $stable(cur_org_x))
		else $error("pattern address changed without commit");

	// Committed address is the snapshot taken at the control write
	addr_commit_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q.arm && tick) |=> cur_addr == $past(st_q.stage_addr))
		else $error("pattern address commit wrong");

	// Snapshot at the control write joins the two address halves
	stage_join_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_CTRL)
		|=> st_q.stage_addr == {$past(st_q.shadow[`HWC_IDX_ADDR_HI][`HWC_BYTE_HI:0]),
			$past(st_q.shadow[`HWC_IDX_ADDR_LO])})
		else $error("address snapshot wrong");

	// Committed origin is the snapshot taken at the control write
	org_commit_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q.arm && tick) |=> {cur_org_y, cur_org_x} == $past(st_q.stage_org))
		else $error("origin commit wrong");

	// A control write always leaves a commit pending
	arm_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_CTRL) |=> st_q.arm)
		else $error("control write did not arm commit");

	// Position changes only right after a frame or field start
	pos_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!tick |=> $stable(cur_pos_x) && $stable(cur_pos_y))
		else $error("position changed between frames");

	// Readback returns the last written word even before it applies
	readback_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_ADDR_LO) |=> st_q.shadow[`HWC_IDX_ADDR_LO] == $past(acc.data))
		else $error("shadow not updated by write");

	// Unused indices read zero data
	empty_index_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.rd && acc.idx >= 4'(`HWC_NUM_REGS)) |=> io_rdata[`HWC_WORD_DATA_HI:0] == `HWC_RST_WORD)
		else $error("unused index read nonzero");

	// Colour write shows on the colour output next cycle
	colour_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_COL_FIRST) |=> col_first == $past(acc.data[`HWC_BYTE_HI:0]))
		else $error("primary colour not updated");

	// Auxiliary colour follows its write as well
	colour_third_a: assert property (@(posedge clock) disable iff (!rst_n)
		(acc.wr && acc.idx == `HWC_IDX_COL_THIRD) |=> col_third == $past(acc.data[`HWC_BYTE_HI:0]))
		else $error("auxiliary colour not updated");

	// Index control write loads the block pointer
	ic_pointer_a: assert property (@(posedge clock) disable iff (!rst_n)
		(io_req.sel && io_req.wr && io_req.port == `HWC_PORT_IC && io_req.be[0])
		|=> ic_word[`HWC_IC_PTR_HI:0] == $past(io_req.wdata[`HWC_IC_PTR_HI:0]))
		else $error("block pointer not loaded");

	// Access-port read with another block selected answers zero
	foreign_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		(io_req.sel && io_req.rd && io_req.port == `HWC_PORT_ACC && !acc.rd)
		|=> io_rvalid && io_rdata == 16'h0000)
		else $error("other block read not zero");

	// Read valid only answers a read strobe
	rvalid_only_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(io_req.sel && io_req.rd) |=> !io_rvalid)
		else $error("read valid without a read");

	// A hidden cursor never hits on the next cycle
	hit_hidden_a: assert property (@(posedge clock) disable iff (!rst_n)
		!cur_shown |=> !cur_hit)
		else $error("cursor hit while hidden");

	// The small pattern never reaches a column or row past 31
	small_window_a: assert property (@(posedge clock) disable iff (!rst_n)
		(cur_hit && $past(cur_ctl.size) == `HWC_SIZE_32) |-> !pat_col[5] && !pat_row[5])
		else $error("hit outside the small pattern");

	// Position takes its shadow on every frame or field tick
	pos_commit_a: assert property (@(posedge clock) disable iff (!rst_n)
		tick |=> cur_pos_x == $past(st_q.shadow[`HWC_IDX_POS_X][`HWC_POS_HI:0])
			&& cur_pos_y == $past(st_q.shadow[`HWC_IDX_POS_Y][`HWC_POS_HI:0]))
		else $error("position not committed on tick");

endmodule : hwc_cursor
`default_nettype wire

// File: verification/hwc_cursor_test.sv
// Self-checking testbench for the hardware cursor register block
`include "hwc_consts.svh"
`default_nettype none
module hwc_cursor_test;
	timeunit 1ns;
	timeprecision 1ps;
	import hwc_pkg::*;

	logic        clock;
	logic        rst_n;
	hwc_io_req_s io_req;
	logic [15:0] io_rdata;
	logic        io_rvalid;
	logic        frame_start;
	logic        field_start;
	logic        interlaced;
	logic [10:0] beam_x;
	logic [10:0] beam_y;
	logic        cur_shown;
	hwc_ctl_s    cur_ctl;
	logic [19:0] cur_addr;
	logic [5:0]  cur_org_x;
	logic [5:0]  cur_org_y;
	logic [10:0] cur_pos_x;
	logic [10:0] cur_pos_y;
	logic [7:0]  col_first;
	logic [7:0]  col_second;
	logic [7:0]  col_third;
	logic        cur_hit;
	logic [5:0]  pat_col;
	logic [5:0]  pat_row;
	int          n_errors;
	int          n_tests;
	integer      seed;
	logic [15:0] exp_q[$];   // Read words still owed by the block
	logic [11:0] mdl[16];    // Last written data per index, unused ones stay zero
	logic [19:0] old_addr;   // Applied address expected before the commit
	logic [19:0] stg_addr;   // Address captured by the last control write
	logic [21:0] old_pos;    // Applied position expected before the frame

	hwc_cursor dut_u (
		.clock, .rst_n, .io_req, .io_rdata, .io_rvalid, .frame_start, .field_start, .interlaced,
		.beam_x, .beam_y, .cur_shown, .cur_ctl, .cur_addr, .cur_org_x, .cur_org_y, .cur_pos_x,
		.cur_pos_y, .col_first, .col_second, .col_third, .cur_hit, .pat_col, .pat_row
	);

	// Free-running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		if (n_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// Holds one request for n edges, then idles a cycle so no strobe changes twice in one step
	task automatic io_op(input logic wr, input logic port, input logic [1:0] be, input logic [15:0] d, input int n);
		io_req = '{sel: 1'b1, wr: wr, rd: !wr, port: port, be: be, wdata: d};
		repeat (n) @(negedge clock);
		io_req = '0;
		@(negedge clock);
	endtask : io_op

	// Index control write: cursor block pointer, start index and auto-increment disable
	task automatic sel(input logic [3:0] idx, input logic aid);
		io_op(1'b1, `HWC_PORT_ACC ^ 1'b1, `HWC_BE_BOTH, {3'h0, aid, idx, `HWC_BLOCK_CURSOR}, 1);
	endtask : sel

	// Full-word write at the access port; indices past 8 must be dropped
	task automatic put(input logic [3:0] idx, input logic [11:0] d);
		io_op(1'b1, `HWC_PORT_ACC, `HWC_BE_BOTH, {idx, d}, 1);
		if (idx < 4'h9) begin
			mdl[idx] = d;
		end
		if (idx == `HWC_IDX_CTRL) begin
			stg_addr = {mdl[2][7:0], mdl[1]};
		end
	endtask : put

	// Back-to-back reads with the strobe held, expected words queued first
	task automatic rd(input logic [3:0] start, input int n, input logic aid);
		logic [3:0] idx;
		sel(start, aid);
		for (int i = 0; i < n; i++) begin
			idx = aid ? start : start + 4'(i);
			exp_q.push_back({idx, mdl[idx]});
		end
		io_op(1'b0, `HWC_PORT_ACC, `HWC_BE_BOTH, 16'h0000, n);
	endtask : rd

	// Bounded wait until every queued read has been answered
	task automatic drain;
		for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clock);
		if (exp_q.size() > 0) begin
			check("read answers", 32'h1, 32'h0);
			end_sim();
		end
	endtask : drain

	// One-cycle frame or field tick; applied values are settled when this returns
	task automatic tick(input logic fld);
		if (fld) begin
			field_start = 1'b1;
		end else begin
			frame_start = 1'b1;
		end
		@(negedge clock);
		field_start = 1'b0;
		frame_start = 1'b0;
		@(negedge clock);
	endtask : tick

	// Read answer watcher: each valid pulse consumes the oldest expected word
	always @(negedge clock) begin
		if (io_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected read", 32'h1, 32'h0);
			end else begin
				check("io_rdata", io_rdata, exp_q.pop_front());
			end
		end
	end

	// Main sequence
	initial begin
		seed = 32'h07E3;
		n_errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		io_req = '0;
		frame_start = 1'b0;
		field_start = 1'b0;
		interlaced = 1'b0;
		beam_x = 11'h000;
		beam_y = 11'h000;
		foreach (mdl[i]) mdl[i] = 12'h000;
		stg_addr = 20'h00000;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		check("reset shown", {cur_shown, cur_hit, cur_pos_x}, 32'h0);
		check("reset address", cur_addr, 32'h0);

		// Random data into every index, unused ones included, then a wrapping read sweep
		sel(4'h0, 1'b0);
		for (int i = 0; i < 16; i++) put(i[3:0], 12'($random(seed)));
		rd(4'h0, 17, 1'b0);
		drain();
		check("colours", {col_first, col_second, col_third}, {mdl[3][7:0], mdl[4][7:0], mdl[8][7:0]});
		rd(4'h5, 3, 1'b1);
		drain();

		// Other block selected: writes dropped, reads answer zero
		io_op(1'b1, 1'b0, `HWC_BE_BOTH, 16'h0001, 1);
		io_op(1'b1, `HWC_PORT_ACC, `HWC_BE_BOTH, {`HWC_IDX_COL_FIRST, 12'hABC}, 1);
		exp_q.push_back(16'h0000);
		io_op(1'b0, `HWC_PORT_ACC, `HWC_BE_BOTH, 16'h0000, 1);
		// Index control read: invalid block flag set, index unmoved, pointer 01h
		exp_q.push_back(16'h2001);
		io_op(1'b0, 1'b0, `HWC_BE_BOTH, 16'h0000, 1);
		sel(4'h0, 1'b0);
		io_op(1'b1, `HWC_PORT_ACC, 2'b01, {`HWC_IDX_COL_FIRST, 12'h0FF}, 1);
		rd(`HWC_IDX_COL_FIRST, 1, 1'b0);
		drain();

		// Staged values wait for their frame; address and origin also wait for a control write
		tick(1'b0);
		old_addr = stg_addr;
		old_pos = {mdl[6][10:0], mdl[7][10:0]};
		put(`HWC_IDX_POS_X, 12'h0C8);
		put(`HWC_IDX_POS_Y, 12'h032);
		put(`HWC_IDX_ORIGIN, {6'd2, 6'd3});
		put(`HWC_IDX_ADDR_LO, 12'($random(seed)));
		put(`HWC_IDX_ADDR_HI, 12'($random(seed)));
		check("pos before frame", {cur_pos_x, cur_pos_y}, old_pos);
		tick(1'b0);
		check("pos after frame", {cur_pos_x, cur_pos_y}, {11'd200, 11'd50});
		check("addr no ctrl", cur_addr, old_addr);
		put(`HWC_IDX_CTRL, 12'h800);
		check("addr before frame", cur_addr, old_addr);
		rd(`HWC_IDX_ADDR_LO, 2, 1'b0);
		drain();
		// A low half written after the control write must wait for the next one
		put(`HWC_IDX_ADDR_LO, 12'($random(seed)));
		tick(1'b0);
		check("addr applied", cur_addr, stg_addr);
		check("origin applied", {cur_org_y, cur_org_x}, {6'd2, 6'd3});

		// Field ticks are ignored unless interlaced, and then only they count
		put(`HWC_IDX_POS_X, 12'h7FF);
		tick(1'b1);
		check("pos field flat", cur_pos_x, 11'd200);
		interlaced = 1'b1;
		tick(1'b0);
		check("pos frame tick", cur_pos_x, 11'd200);
		tick(1'b1);
		check("pos field tick", cur_pos_x, 11'h7FF);
		put(`HWC_IDX_POS_X, 12'h0C8);
		tick(1'b1);

		// Every size, protection and colour-mode code
		for (int c = 0; c < 64; c++) begin
			put(`HWC_IDX_CTRL, {1'b1, c[5:4], c[3], c[2:0], 5'h00});
			check("cur_shown", cur_shown, c[5:4] < 2'b10 && !c[2]);
			check("cur_ctl", cur_ctl, {1'b1, c[5:4], c[3], c[2:0]});
		end
		put(`HWC_IDX_CTRL, 12'h200);
		check("disabled", cur_shown, 1'b0);
		put(`HWC_IDX_CTRL, 12'h800);
		check("enabled", cur_shown, 1'b1);

		// Hot spot drawn at the position, 32-wide window edge
		beam_x = 11'd200;
		beam_y = 11'd50;
		repeat (2) @(negedge clock);
		check("hit at hot spot", {cur_hit, pat_col, pat_row}, {1'b1, 6'd3, 6'd2});
		beam_x = 11'd229;
		repeat (2) @(negedge clock);
		check("past window edge", cur_hit, 1'b0);
		end_sim();
	end
endmodule : hwc_cursor_test
`default_nettype wire
